// ### verilog/scu_command_unit.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Execute a command only after carriage return
// - Every sent message except the one-byte paper query ends CR then LF
// - Two seconds idle clears the receive buffer
// - Echo setting retransmits received characters
// - Reply starts under 25 ms after CR
// - Two letters, optional value, no separator
// - Command letters are case insensitive
// - Unknown commands get an invalid message
// - Unit identifier 0 to 99; zero always answers
// - Nonzero unit answers only once selected
// - Selection persists across later commands
// - Bare unit query returns own identifier
// - Select accepts leading zeros, sends nothing
// - Clear trip total; rate query sends rate
// - Totals reply: identifier, trip, accumulated, CRLF
// - Reset key prints ticket, then clears total
// - Slip printer queried for paper first
// - Optional clear-to-send pauses ticket output
// - Ticket counter increments, printed with ID, time
// - Baud and parity configured outside, must match
module scu_command_unit
    import scu_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = scu_pkg::CHAR_GAP_CYC,
    parameter int unsigned REPLY_CYCLES   = scu_pkg::REPLY_CYC,
    parameter int unsigned DEPTH          = scu_pkg::BUF_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        rxValid,       // UART framing set to host baud, parity
    input  wire logic [7:0]  rxData,
    input  wire logic        txReady,
    output logic             txValid,
    output logic      [7:0]  txData,
    input  wire logic        echoEnable,
    input  wire logic [6:0]  unitId,
    input  wire logic        slipPrinter,
    input  wire logic        ctsEnable,
    input  wire logic        ctsPin,
    input  wire logic        resetKey,
    input  wire logic [31:0] rateBcd,
    input  wire logic [31:0] tripTotalBcd,
    input  wire logic [31:0] accumTotalBcd,
    input  wire logic [31:0] timeStampBcd,
    output logic             clearTotal,
    output logic      [15:0] ticketCount,
    output logic             unitSelected,
    output logic             paperOut
);
    import scu_pkg::*;

    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned PW = AW + 1;
    localparam int unsigned GW = $clog2(TIMEOUT_CYCLES + 1);
    localparam logic [GW-1:0] GAP_END = GW'(TIMEOUT_CYCLES);

    typedef struct packed {
        scu_state_t     state;
        scu_msg_t       msg;
        logic [5:0]     idx;
        logic [PW-1:0]  wrPtr;
        logic [PW-1:0]  cmdLen;
        logic [PW-1:0]  rdIdx;
        logic [PW-1:0]  pos;
        logic           rdPend;
        logic           crPend;
        logic           ovf;
        logic           ovfCmd;
        logic [GW-1:0]  gap;
        logic [7:0]     l0;
        logic [7:0]     l1;
        logic [6:0]     val;
        logic           hasVal;
        logic           big;
        logic           bad;
        logic           selected;
        logic           txValid;
        logic [7:0]     txData;
        logic           clearTotal;
        logic [15:0]    ticketCount;
        logic           paperOut;
        logic           ctsMeta;
        logic           ctsSync;
        logic           keyMeta;
        logic           keySync;
        logic           keyPrev;
        logic           keyPend;
    } scu_regs_t;

    scu_regs_t      s;
    scu_regs_t      next_s;
    logic           memWe;
    logic           memRe;
    logic [7:0]     memData;
    logic [6:0]     idTens;
    logic [6:0]     idOnes;
    logic           canLoad;
    logic           blocked;
    logic           crEvent;
    logic [8:0]     msgOut;
    logic [10:0]    accum;
    logic [7:0]     upper;

    scu_cmd_buffer #(
        .WIDTH (8),
        .DEPTH (DEPTH)
    ) u_buffer (
        .clk       (clk),
        .rstn      (rstn),
        .writeEn   (memWe),
        .writeAddr (s.wrPtr[AW-1:0]),
        .writeData (rxData),
        .readEn    (memRe),
        .readAddr  (s.rdIdx[AW-1:0]),
        .readData  (memData)
    );

    function automatic logic [7:0] dig(input logic [3:0] n);
        return CHAR_ZERO | {4'h0, n};
    endfunction : dig

    function automatic logic [7:0] dig32(input logic [31:0] v, input logic [5:0] k);
        logic [2:0] j;
        j = 3'(k);
        return dig(v[(3'h7 - j) * 4 +: 4]);
    endfunction : dig32

    function automatic logic [15:0] bcdInc(input logic [15:0] v);
        logic [15:0] r;
        logic        carry;
        r = v;
        carry = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            if (carry)
            begin
                if (r[k*4 +: 4] == BCD_NINE)
                begin
                    r[k*4 +: 4] = 4'h0;
                end
                else
                begin
                    r[k*4 +: 4] = r[k*4 +: 4] + 4'h1;
                    carry = 1'b0;
                end
            end
        end
        return r;
    endfunction : bcdInc

    // Message byte and last flag; every text message closes with CR, LF
    function automatic logic [8:0] msgChar(input scu_msg_t m, input logic [5:0] i);
        logic [7:0] c;
        logic [5:0] crAt;
        c = CHAR_SPACE;
        crAt = 6'h02;
        case (m)
            MSG_ID:
            begin
                crAt = 6'h02;
                if (i < 6'h02) c = (i == 6'h00) ? dig(idTens[3:0]) : dig(idOnes[3:0]);
            end
            MSG_RATE:
            begin
                crAt = 6'h08;
                if (i < 6'h08) c = dig32(rateBcd, i);
            end
            MSG_TOTALS:
            begin
                crAt = 6'h14;
                if (i < 6'h02) c = (i == 6'h00) ? dig(idTens[3:0]) : dig(idOnes[3:0]);
                else if (i >= 6'h03 && i < 6'h0b) c = dig32(tripTotalBcd, i - 6'h03);
                else if (i >= 6'h0c && i < 6'h14) c = dig32(accumTotalBcd, i - 6'h0c);
            end
            MSG_INVALID:
            begin
                crAt = 6'h07;
                case (i)
                    6'h00, 6'h05: c = CMD_I;
                    6'h01:        c = CHAR_N;
                    6'h02:        c = CHAR_V;
                    6'h03:        c = CHAR_A;
                    6'h04:        c = CHAR_L;
                    6'h06:        c = CMD_D;
                    default:      c = CHAR_SPACE;
                endcase
            end
            MSG_TICKET:
            begin
                crAt = 6'h22;
                if (i < 6'h02) c = (i == 6'h00) ? dig(idTens[3:0]) : dig(idOnes[3:0]);
                else if (i >= 6'h03 && i < 6'h07) c = dig(s.ticketCount[(6'h06 - i) * 4 +: 4]);
                else if (i >= 6'h08 && i < 6'h10) c = dig32(timeStampBcd, i - 6'h08);
                else if (i >= 6'h11 && i < 6'h19) c = dig32(tripTotalBcd, i - 6'h11);
                else if (i >= 6'h1a && i < 6'h22) c = dig32(accumTotalBcd, i - 6'h1a);
            end
            default:
            begin
                return {1'b1, PAPER_QUERY};
            end
        endcase
        if (i == crAt) c = CHAR_CR;
        if (i == crAt + 6'h01) c = CHAR_LF;
        return {i == crAt + 6'h01, c};
    endfunction : msgChar

    always_comb
    begin
        idTens = 7'(unitId / DEC_BASE);
        idOnes = 7'(unitId % DEC_BASE);
        canLoad = !s.txValid || txReady;
        blocked = (s.msg == MSG_TICKET) && ctsEnable && !s.ctsSync;
        msgOut = msgChar(s.msg, s.idx);
        upper = memData;
        if (memData >= CHAR_LOW_A && memData <= CHAR_LOW_Z)
        begin
            upper = memData - CASE_OFFSET;
        end
        accum = 11'(s.val) * 11'(DEC_BASE) + 11'(memData - CHAR_ZERO);
        next_s = s;
        memWe = 1'b0;
        memRe = 1'b0;
        crEvent = 1'b0;
        next_s.ctsMeta = ctsPin;
        next_s.ctsSync = s.ctsMeta;
        next_s.keyMeta = resetKey;
        next_s.keySync = s.keyMeta;
        next_s.keyPrev = s.keySync;
        next_s.clearTotal = 1'b0;
        if (s.txValid && txReady)
        begin
            next_s.txValid = 1'b0;
        end
        if (rxValid)
        begin
            next_s.gap = '0;
        end
        else if (s.gap < GAP_END)
        begin
            next_s.gap = s.gap + GW'(1);
            if (s.gap == GAP_END - GW'(1))
            begin
                next_s.wrPtr = '0;
                next_s.ovf = 1'b0;
            end
        end
        // The paper reply belongs to the printer, not to the command stream
        if (rxValid && s.state != SCU_PAPER)
        begin
            if (rxData == CHAR_CR)
            begin
                crEvent = 1'b1;
                next_s.cmdLen = s.wrPtr;
                next_s.ovfCmd = s.ovf;
                next_s.wrPtr = '0;
                next_s.ovf = 1'b0;
            end
            else if (s.wrPtr < PW'(DEPTH))
            begin
                memWe = 1'b1;
                next_s.wrPtr = s.wrPtr + PW'(1);
            end
            else
            begin
                next_s.ovf = 1'b1;
            end
            // Echo dropped while a reply or ticket owns the line
            if (echoEnable && s.state != SCU_SEND && canLoad)
            begin
                next_s.txValid = 1'b1;
                next_s.txData = rxData;
            end
        end
        case (s.state)
            SCU_IDLE:
            begin
                if (s.crPend)
                begin
                    next_s.crPend = 1'b0;
                    next_s.state = SCU_PARSE;
                    next_s.rdIdx = '0;
                    next_s.rdPend = 1'b0;
                    next_s.l0 = '0;
                    next_s.l1 = '0;
                    next_s.val = '0;
                    next_s.hasVal = 1'b0;
                    next_s.big = 1'b0;
                    next_s.bad = s.ovfCmd || (s.cmdLen < PW'(CMD_LETTERS));
                end
                else if (s.keyPend)
                begin
                    next_s.keyPend = 1'b0;
                    next_s.idx = '0;
                    next_s.msg = slipPrinter ? MSG_QUERY : MSG_TICKET;
                    next_s.state = SCU_SEND;
                end
            end
            SCU_PARSE:
            begin
                memRe = s.rdIdx < s.cmdLen;
                if (memRe)
                begin
                    next_s.rdIdx = s.rdIdx + PW'(1);
                end
                next_s.rdPend = memRe;
                next_s.pos = s.rdIdx;
                if (s.rdPend)
                begin
                    if (s.pos == '0)
                    begin
                        next_s.l0 = upper;
                    end
                    else if (s.pos == PW'(1))
                    begin
                        next_s.l1 = upper;
                    end
                    else if (memData >= CHAR_ZERO && memData <= CHAR_NINE)
                    begin
                        // Leading zeros simply accumulate to nothing
                        next_s.hasVal = 1'b1;
                        if (s.big || accum > 11'(MAX_UNIT))
                        begin
                            next_s.big = 1'b1;
                        end
                        else
                        begin
                            next_s.val = accum[6:0];
                        end
                    end
                    else
                    begin
                        next_s.bad = 1'b1;
                    end
                end
                if (!memRe && !s.rdPend)
                begin
                    next_s.state = SCU_EXEC;
                end
            end
            SCU_EXEC:
            begin
                next_s.state = SCU_IDLE;
                next_s.idx = '0;
                if (s.l0 == CMD_I && s.l1 == CMD_D && !s.bad && s.hasVal)
                begin
                    next_s.selected = !s.big && s.val == unitId;
                end
                else if (unitId == '0 || s.selected)
                begin
                    next_s.state = SCU_SEND;
                    next_s.msg = MSG_INVALID;
                    if (s.bad || s.hasVal)
                    begin
                        next_s.msg = MSG_INVALID;
                    end
                    else if (s.l0 == CMD_I && s.l1 == CMD_D)
                    begin
                        next_s.msg = MSG_ID;
                    end
                    else if (s.l0 == CMD_T && s.l1 == CMD_R)
                    begin
                        next_s.clearTotal = 1'b1;
                        next_s.state = SCU_IDLE;
                    end
                    else if (s.l0 == CMD_T && s.l1 == CMD_QUERY)
                    begin
                        next_s.msg = MSG_TOTALS;
                    end
                    else if (s.l0 == CMD_R && s.l1 == CMD_QUERY)
                    begin
                        next_s.msg = MSG_RATE;
                    end
                end
            end
            SCU_SEND:
            begin
                if (canLoad && !blocked)
                begin
                    next_s.txValid = 1'b1;
                    next_s.txData = msgOut[7:0];
                    next_s.idx = s.idx + 6'h01;
                    if (msgOut[8])
                    begin
                        next_s.gap = '0;
                        if (s.msg == MSG_QUERY) next_s.state = SCU_PAPER;
                        else if (s.msg == MSG_TICKET) next_s.state = SCU_FINISH;
                        else next_s.state = SCU_IDLE;
                    end
                end
            end
            SCU_PAPER:
            begin
                if (rxValid)
                begin
                    next_s.paperOut = (rxData & PAPER_MASK) != '0;
                    next_s.msg = MSG_TICKET;
                    next_s.idx = '0;
                    next_s.state = ((rxData & PAPER_MASK) == '0) ? SCU_SEND : SCU_IDLE;
                end
                else if (s.gap == GAP_END)
                begin
                    next_s.paperOut = 1'b1;
                    next_s.state = SCU_IDLE;
                end
            end
            default:
            begin
                // Clear only once the last ticket byte has left
                if (!s.txValid)
                begin
                    next_s.clearTotal = 1'b1;
                    next_s.ticketCount = bcdInc(s.ticketCount);
                    next_s.state = SCU_IDLE;
                end
            end
        endcase
        if (crEvent)
        begin
            next_s.crPend = 1'b1;
        end
        if (s.keySync && !s.keyPrev)
        begin
            next_s.keyPend = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign txValid      = s.txValid;
    assign txData       = s.txData;
    assign clearTotal   = s.clearTotal;
    assign ticketCount  = s.ticketCount;
    assign unitSelected = s.selected;
    assign paperOut     = s.paperOut;

    // Cycles from a CR taken in idle until the reply's first byte
    logic [31:0] replyAge;
    logic        replyWait;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            replyAge  <= '0;
            replyWait <= 1'b0;
        end
        else if ((s.state == SCU_SEND && canLoad) || (s.state == SCU_EXEC && next_s.state == SCU_IDLE))
        begin
            replyWait <= 1'b0;
            replyAge  <= '0;
        end
        else if (crEvent && s.state == SCU_IDLE && !s.keyPend)
        begin
            replyWait <= 1'b1;
            replyAge  <= '0;
        end
        else if (replyWait)
        begin
            replyAge <= replyAge + 32'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence seqSelectExec;
        s.state == SCU_EXEC && s.l0 == CMD_I && s.l1 == CMD_D && !s.bad && s.hasVal;
    endsequence
    sequence seqTicketDone;
        s.state == SCU_FINISH && !s.txValid;
    endsequence

    chk_no_cr_no_parse: assert property (s.state == SCU_IDLE && !s.crPend |=> s.state != SCU_PARSE)
        else $error("parse started without a carriage return");
    chk_line_end: assert property (s.state == SCU_SEND && canLoad && !blocked && msgOut[8]
        && s.msg != MSG_QUERY |-> msgOut[7:0] == CHAR_LF && s.txData == CHAR_CR)
        else $error("message did not end with CR LF");
    chk_gap_clear: assert property (s.gap == GAP_END - GW'(1) && !rxValid |=> s.wrPtr == '0)
        else $error("receive buffer kept after character timeout");
    chk_echo_copy: assert property (rxValid && echoEnable && s.state != SCU_SEND && s.state != SCU_PAPER
        && canLoad |=> s.txValid && s.txData == $past(rxData))
        else $error("received character not echoed");
    chk_reply_time: assert property (replyAge < REPLY_CYCLES)
        else $error("reply started too late");
    chk_case_fold: assert property (s.state == SCU_PARSE && s.rdPend && s.pos == '0
        |=> !(s.l0 >= CHAR_LOW_A && s.l0 <= CHAR_LOW_Z))
        else $error("lower case letter kept");
    chk_quiet_unaddr: assert property (s.state == SCU_EXEC && unitId != '0 && !s.selected
        && !(s.l0 == CMD_I && s.l1 == CMD_D && !s.bad && s.hasVal) |=> s.state == SCU_IDLE)
        else $error("unselected unit answered");
    chk_select_silent: assert property (seqSelectExec |=> s.state == SCU_IDLE
        && s.selected == ($past(s.val) == $past(unitId) && !$past(s.big)))
        else $error("select command misbehaved");
    chk_ticket_clear: assert property (seqTicketDone |=> s.clearTotal
        && s.ticketCount != $past(s.ticketCount) ##1 !s.clearTotal)
        else $error("ticket end did not clear total once");
    chk_cts_hold: assert property (s.state == SCU_SEND && blocked && !s.txValid |=> !s.txValid)
        else $error("ticket byte sent while printer busy");
    chk_paper_first: assert property (slipPrinter && s.state == SCU_IDLE && !s.crPend && s.keyPend
        |=> s.msg == MSG_QUERY)
        else $error("slip ticket started without paper query");
endmodule : scu_command_unit

// ### verilog/scu_pkg.sv
package scu_pkg;
    localparam int unsigned CLK_HZ       = 25_000_000;
    localparam int unsigned MS_PER_S     = 1000;
    localparam int unsigned CHAR_GAP_MS  = 2000;
    localparam int unsigned CHAR_GAP_CYC = CLK_HZ / MS_PER_S * CHAR_GAP_MS;
    localparam int unsigned REPLY_MS     = 25;
    localparam int unsigned REPLY_CYC    = CLK_HZ / MS_PER_S * REPLY_MS;
    localparam int unsigned BUF_DEPTH    = 32;

    localparam logic [7:0] CHAR_CR     = 8'h0d;
    localparam logic [7:0] CHAR_LF     = 8'h0a;
    localparam logic [7:0] CHAR_SPACE  = 8'h20;
    localparam logic [7:0] CHAR_ZERO   = 8'h30;
    localparam logic [7:0] CHAR_NINE   = 8'h39;
    localparam logic [7:0] CHAR_LOW_A  = 8'h61;
    localparam logic [7:0] CHAR_LOW_Z  = 8'h7a;
    localparam logic [7:0] CASE_OFFSET = 8'h20;
    localparam logic [7:0] CMD_I       = 8'h49;
    localparam logic [7:0] CMD_D       = 8'h44;
    localparam logic [7:0] CMD_T       = 8'h54;
    localparam logic [7:0] CMD_R       = 8'h52;
    localparam logic [7:0] CMD_QUERY   = 8'h3f;
    localparam logic [7:0] CHAR_N      = 8'h4e;
    localparam logic [7:0] CHAR_V      = 8'h56;
    localparam logic [7:0] CHAR_A      = 8'h41;
    localparam logic [7:0] CHAR_L      = 8'h4c;
    localparam logic [7:0] PAPER_QUERY = 8'h05;
    localparam logic [7:0] PAPER_MASK  = 8'h0c;
    localparam logic [6:0] MAX_UNIT    = 7'h63;
    localparam logic [6:0] DEC_BASE    = 7'h0a;
    localparam logic [3:0] BCD_NINE    = 4'h9;
    localparam int unsigned CMD_LETTERS = 2;

    typedef enum logic [2:0] {
        SCU_IDLE   = 3'h0,
        SCU_PARSE  = 3'h1,
        SCU_EXEC   = 3'h3,
        SCU_SEND   = 3'h2,
        SCU_PAPER  = 3'h6,
        SCU_FINISH = 3'h7
    } scu_state_t;

    typedef enum logic [2:0] {
        MSG_ID      = 3'h0,
        MSG_TOTALS  = 3'h1,
        MSG_RATE    = 3'h2,
        MSG_INVALID = 3'h3,
        MSG_TICKET  = 3'h4,
        MSG_QUERY   = 3'h5
    } scu_msg_t;
endpackage : scu_pkg

// ### verilog/scu_cmd_buffer.sv
`timescale 1ns/1ns
module scu_cmd_buffer #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32,
    parameter int unsigned AW    = $clog2(DEPTH)
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             writeEn,
    input  wire logic [AW-1:0]    writeAddr,
    input  wire logic [WIDTH-1:0] writeData,
    input  wire logic             readEn,
    input  wire logic [AW-1:0]    readAddr,
    output logic      [WIDTH-1:0] readData
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]            rd;
    } scu_buf_t;

    scu_buf_t s;
    scu_buf_t next_s;

    always_comb
    begin
        next_s = s;
        if (writeEn)
        begin
            next_s.mem[writeAddr] = writeData;
        end
        if (readEn)
        begin
            next_s.rd = s.mem[readAddr];
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign readData = s.rd;
endmodule : scu_cmd_buffer

// ### verification/scu_host_model.sv
`timescale 1ns/1ns
module scu_host_model (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic slow,
    input  wire logic txValid,
    output logic      txReady,
    output logic      taken
);
    // Slow host takes every other cycle, so held bytes are exercised
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
            txReady <= 1'b0;
        else
            txReady <= slow ? !txReady : 1'b1;
    assign taken = txValid && txReady;
endmodule : scu_host_model

// ### verification/tb_serial_ascii_command_unit.sv
`timescale 1ns/1ns
module tb_serial_ascii_command_unit;
    import scu_pkg::*;
    logic        clk, rstn, rxValid, txReady, txValid, slow, echo, cts, key, taken;
    logic        clearTotal, unitSelected, paperOut, slip, ctsEn;
    logic [7:0]  rxData, txData;
    logic [6:0]  unitId;
    logic [15:0] ticketCount;
    logic [31:0] rate, trip, accum, stamp;
    logic [7:0]  expQ[$];
    int          fail_count, n_checks, clears, seed;
    scu_command_unit #(.TIMEOUT_CYCLES(200), .REPLY_CYCLES(100)) DUT (
        .clk(clk), .rstn(rstn), .rxValid(rxValid), .rxData(rxData), .txReady(txReady),
        .txValid(txValid), .txData(txData), .echoEnable(echo), .unitId(unitId),
        .slipPrinter(slip), .ctsEnable(ctsEn), .ctsPin(cts), .resetKey(key),
        .rateBcd(rate), .tripTotalBcd(trip), .accumTotalBcd(accum),
        .timeStampBcd(stamp), .clearTotal(clearTotal), .ticketCount(ticketCount),
        .unitSelected(unitSelected), .paperOut(paperOut));
    scu_host_model host (.clk(clk), .rstn(rstn), .slow(slow), .txValid(txValid),
        .txReady(txReady), .taken(taken));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic pushs(input string s);
        for (int i = 0; i < s.len(); i++)
            expQ.push_back(s[i]);
    endtask : pushs
    task automatic crlf();
        expQ.push_back(CHAR_CR);
        expQ.push_back(CHAR_LF);
    endtask : crlf
    task automatic pushd(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
            expQ.push_back(CHAR_ZERO + 8'(v[4*i+:4]));
    endtask : pushd
    task automatic ticket(input logic [15:0] num);
        pushs("05 ");
        pushd(32'(num), 4);
        pushs(" ");
        pushd(stamp, 8);
        pushs(" ");
        pushd(trip, 8);
        pushs(" ");
        pushd(accum, 8);
        crlf();
    endtask : ticket
    task automatic press();
        key = 1'b1;
        repeat (4) @(negedge clk);
        key = 1'b0;
    endtask : press
    task automatic send(input string s, input bit cr);
        for (int i = 0; i < s.len() + cr; i++)
        begin
            @(negedge clk);
            rxValid = 1'b1;
            rxData = (i < s.len()) ? s[i] : CHAR_CR;
            if (echo)
                expQ.push_back(rxData);
            @(negedge clk);
            rxValid = 1'b0;
            repeat (6) @(negedge clk);
        end
    endtask : send
    task automatic drain(input string name);
        int n = 0;
        while (expQ.size() > 0 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 3000)
        begin
            fail_count++;
            complete_run();
        end
        repeat (40) @(negedge clk);
        $display("done %s", name);
    endtask : drain
    // Each byte the host takes is matched against the oldest note
    always @(negedge clk)
    begin
        if (taken)
            check({8'h00, txData}, expQ.size() ? {8'h00, expQ.pop_front()} : 16'hxxxx);
        if (clearTotal)
            clears++;
    end
    initial
    begin
        clk = 1'b0;
        forever #20 clk = !clk;
    end
    initial
    begin
        seed = 65;
        {rstn, rxValid, rxData, slow, echo, cts, key, unitId, slip, ctsEn} = '0;
        rate = 32'($random(seed)) & 32'h77777777;
        trip = 32'($random(seed)) & 32'h77777777;
        accum = 32'($random(seed)) & 32'h77777777;
        stamp = 32'($random(seed)) & 32'h77777777;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        cts = 1'b1;
        send("r?", 1);
        pushd(rate, 8);
        crlf();
        drain("rate");
        send("XY", 1);
        pushs("INVALID");
        crlf();
        drain("invalid");
        echo = 1'b1;
        send("R?", 1);
        pushd(rate, 8);
        crlf();
        drain("echo");
        echo = 1'b0;
        send("TR", 1);
        drain("clear");
        check(16'(clears), 16'h0001);
        unitId = 7'h05;
        send("T?", 1);
        send("ID05", 1);
        drain("select");
        check({15'h0, unitSelected}, 16'h0001);
        send("ID", 1);
        pushs("05");
        crlf();
        drain("query");
        send("T?", 1);
        pushs("05 ");
        pushd(trip, 8);
        pushs(" ");
        pushd(accum, 8);
        crlf();
        drain("totals");
        send("Q", 0);
        repeat (250) @(negedge clk);
        send("R?", 1);
        pushd(rate, 8);
        crlf();
        drain("timeout");
        slow = 1'b1;
        // Busy printer ignored while flow control is off
        cts = 1'b0;
        ticket(16'h0000);
        press();
        drain("ticket");
        check(16'(clears), 16'h0002);
        check(ticketCount, 16'h0001);
        slip = 1'b1;
        ctsEn = 1'b1;
        expQ.push_back(PAPER_QUERY);
        press();
        drain("paper query");
        send("L", 0);
        check({15'h0, paperOut}, 16'h0001);
        expQ.push_back(PAPER_QUERY);
        press();
        drain("second query");
        ticket(16'h0001);
        send("A", 0);
        repeat (20) @(negedge clk);
        check(16'(expQ.size()), 16'h0024);
        cts = 1'b1;
        drain("slip ticket");
        check({15'h0, paperOut}, 16'h0000);
        check(ticketCount, 16'h0002);
        check(16'(clears), 16'h0003);
        complete_run();
    end
endmodule : tb_serial_ascii_command_unit
